// ### verilog/lts_pkg.sv
// shared constants and types for the line test pattern and stamp block
package lts_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AREA = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_LIMITS = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [31:0] MASK_CTRL = 32'h0000_007f;
  localparam logic [31:0] MASK_AREA = 32'h1fff_1fff;
  localparam logic [31:0] MASK_PERIOD = 32'h0000_ffff;
  localparam logic [31:0] MASK_LIMITS = 32'h0fff_0fff;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_AREA = 32'h1000_0000;
  localparam logic [31:0] RST_PERIOD = 32'h0000_1400;
  localparam logic [31:0] RST_LIMITS = 32'h0c80_0190;
  localparam int CTRL_W = 7;
  localparam int AREA_START_LSB = 0;
  localparam int AREA_LEN_LSB = 16;
  localparam int LIM_LO_LSB = 0;
  localparam int LIM_HI_LSB = 16;
  localparam int STAT_BUSY_BIT = 16;
  localparam int STAT_LINEB_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STAMP_LAST = 4'hf;
  localparam logic [7:0] STAMP_SYNC = 8'haa;
  localparam logic [7:0] STAMP_ID_A = 8'h55;
  localparam logic [7:0] STAMP_ID_B = 8'h57;
  localparam logic [11:0] GRAY_8 = 12'h07f;
  localparam logic [11:0] GRAY_10 = 12'h1ff;
  localparam logic [11:0] GRAY_12 = 12'h7ff;

  typedef enum logic [1:0] {TEST_OFF, TEST_RAMP, TEST_BLACK, TEST_GRAY} lts_test_t;
  typedef enum logic [1:0] {DEPTH_8, DEPTH_10, DEPTH_12} lts_depth_t;
  typedef enum logic [1:0] {PH_IDLE, PH_IMAGE, PH_STAMP} lts_phase_t;

  typedef struct packed {
    logic dual;
    logic free_run;
    logic stamp_en;
    lts_depth_t depth;
    lts_test_t test;
  } lts_ctrl_t;

  typedef struct packed {
    logic line_valid;
    logic data_valid;
    logic [11:0] pixel;
  } lts_video_t;
endpackage

// ### verilog/lts_top.sv
// line test pattern generator and line stamp inserter with axi4-lite registers
`timescale 1ns/1ns
module lts_top
  import lts_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic external_line_trigger,
  input wire logic [11:0] sensor_pixel,
  output lts_video_t video
);

  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic [31:0] ctrl, area, period, limits;
  } lts_bus_t;

  typedef struct packed {
    lts_phase_t phase;
    logic [12:0] pos;
    logic [3:0] sidx;
    logic [7:0] ramp, lbase;
    logic [15:0] line_cnt;
    logic line_b;
    logic [23:0] sum, con;
    logic [15:0] hi, lo;
    logic [11:0] prev;
    logic have_prev;
    logic [15:0] fr_cnt;
    lts_video_t vid;
  } lts_vid_t;

  localparam lts_bus_t BUS_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
    ctrl: RST_CTRL, area: RST_AREA, period: RST_PERIOD, limits: RST_LIMITS, default: '0};
  localparam lts_vid_t VID_RST = '{phase: PH_IDLE, default: '0};
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    merge = r & m;
  endfunction
  // places a byte at the output depth, used for ramp and stamp pixels
  function automatic logic [11:0] scale(input logic [7:0] x, input lts_depth_t d);
    case (d)
      DEPTH_8: scale = {4'h0, x};
      DEPTH_10: scale = {2'h0, x, 2'h0};
      default: scale = {x, 4'h0};
    endcase
  endfunction

  lts_bus_t b, next_b;
  lts_vid_t v, next_v;
  logic [2:0] trig_q;
  lts_ctrl_t ctrl;
  logic [12:0] area_start, area_len;
  logic [11:0] lim_lo, lim_hi;

  assign ctrl = lts_ctrl_t'(b.ctrl[CTRL_W-1:0]);
  assign area_start = b.area[AREA_START_LSB +: 13];
  assign area_len = b.area[AREA_LEN_LSB +: 13];
  assign lim_lo = b.limits[LIM_LO_LSB +: 12];
  assign lim_hi = b.limits[LIM_HI_LSB +: 12];

  // register slave: one write and one read in flight; address and data in any order
  always_comb begin
    next_b = b;
    if (awvalid && b.awready) begin
      next_b.awready = 1'b0;
      next_b.waddr = awaddr;
    end
    if (wvalid && b.wready) begin
      next_b.wready = 1'b0;
      next_b.wdat = wdata;
      next_b.wstb = wstrb;
    end
    if (!b.awready && !b.wready && !b.bvalid) begin
      next_b.bvalid = 1'b1;
      next_b.bresp = RESP_OKAY;
      case (b.waddr)
        ADDR_CTRL: next_b.ctrl = merge(b.ctrl, b.wdat, b.wstb, MASK_CTRL);
        ADDR_AREA: next_b.area = merge(b.area, b.wdat, b.wstb, MASK_AREA);
        ADDR_PERIOD: next_b.period = merge(b.period, b.wdat, b.wstb, MASK_PERIOD);
        ADDR_LIMITS: next_b.limits = merge(b.limits, b.wdat, b.wstb, MASK_LIMITS);
        ADDR_STATUS: next_b.bresp = RESP_OKAY;
        default: next_b.bresp = RESP_SLVERR;
      endcase
    end
    if (b.bvalid && bready) begin
      next_b.bvalid = 1'b0;
      next_b.awready = 1'b1;
      next_b.wready = 1'b1;
    end
    if (arvalid && b.arready) begin
      next_b.arready = 1'b0;
      next_b.rvalid = 1'b1;
      next_b.rresp = RESP_OKAY;
      case (araddr)
        ADDR_CTRL: next_b.rdata = b.ctrl;
        ADDR_AREA: next_b.rdata = b.area;
        ADDR_PERIOD: next_b.rdata = b.period;
        ADDR_LIMITS: next_b.rdata = b.limits;
        ADDR_STATUS: next_b.rdata = {14'h0, v.line_b, v.phase != PH_IDLE, v.line_cnt};
        default: begin
          next_b.rdata = 32'h0;
          next_b.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (b.rvalid && rready) begin
      next_b.rvalid = 1'b0;
      next_b.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b <= BUS_RST;
    end else begin
      b <= next_b;
    end
  end

  // two stages resync the pin; the third only delays it for the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= 3'h0;
    end else begin
      trig_q <= {trig_q[1:0], external_line_trigger};
    end
  end

  logic fr_tick, trig, last_img;
  logic [12:0] abs_pos;
  logic [7:0] ramp_px, sbyte;
  logic [11:0] px, diff;

  assign fr_tick = ctrl.free_run && (v.fr_cnt >= b.period[15:0]);
  assign trig = ctrl.free_run ? fr_tick : (trig_q[1] && !trig_q[2]);
  assign abs_pos = area_start + v.pos;
  assign ramp_px = v.lbase + abs_pos[7:0];
  assign last_img = (v.pos == area_len - 13'h1);
  assign diff = (px > v.prev) ? px - v.prev : v.prev - px;

  always_comb begin
    case (ctrl.test)
      TEST_RAMP: px = scale(ramp_px, ctrl.depth);
      TEST_BLACK: px = 12'h0;
      TEST_GRAY: begin
        case (ctrl.depth)
          DEPTH_8: px = GRAY_8;
          DEPTH_10: px = GRAY_10;
          default: px = GRAY_12;
        endcase
      end
      default: px = sensor_pixel;
    endcase
  end

  // stamp contents; the statistics are frozen once the image part ends
  always_comb begin
    case (v.sidx)
      4'h0: sbyte = STAMP_SYNC;
      // line b only counts while dual mode is on; a stale flag must not leak out
      4'h1: sbyte = (ctrl.dual && v.line_b) ? STAMP_ID_B : STAMP_ID_A;
      4'h2: sbyte = v.line_cnt[7:0];
      4'h3: sbyte = v.line_cnt[15:8];
      4'h4: sbyte = v.sum[7:0];
      4'h5: sbyte = v.sum[15:8];
      4'h6: sbyte = v.sum[23:16];
      4'h8: sbyte = v.hi[7:0];
      4'h9: sbyte = v.hi[15:8];
      4'ha: sbyte = v.lo[7:0];
      4'hb: sbyte = v.lo[15:8];
      4'hc: sbyte = v.con[7:0];
      4'hd: sbyte = v.con[15:8];
      4'he: sbyte = v.con[23:16];
      default: sbyte = 8'h0;
    endcase
  end

  always_comb begin
    next_v = v;
    next_v.vid = '0;
    next_v.fr_cnt = fr_tick ? 16'h0 : v.fr_cnt + 16'h1;
    if (trig) next_v.ramp = v.ramp + 8'h1;
    case (v.phase)
      PH_IDLE: begin
        // a trigger during a line is dropped so lines never overlap
        if (trig && area_len != 13'h0) begin
          next_v.phase = PH_IMAGE;
          next_v.lbase = v.ramp;
          next_v.pos = 13'h0;
          next_v.sum = 24'h0;
          next_v.con = 24'h0;
          next_v.hi = 16'h0;
          next_v.lo = 16'h0;
          next_v.have_prev = 1'b0;
        end
      end
      PH_IMAGE: begin
        next_v.vid = '{line_valid: 1'b1, data_valid: 1'b1, pixel: px};
        next_v.pos = v.pos + 13'h1;
        next_v.sum = v.sum + {12'h0, px};
        if (px > lim_hi) next_v.hi = v.hi + 16'h1;
        if (px < lim_lo) next_v.lo = v.lo + 16'h1;
        if (v.have_prev) next_v.con = v.con + {12'h0, diff};
        next_v.prev = px;
        next_v.have_prev = 1'b1;
        if (last_img) begin
          next_v.phase = ctrl.stamp_en ? PH_STAMP : PH_IDLE;
          next_v.sidx = 4'h0;
        end
      end
      PH_STAMP: begin
        next_v.vid = '{line_valid: 1'b1, data_valid: 1'b1,
                       pixel: scale(sbyte, ctrl.depth)};
        next_v.sidx = v.sidx + 4'h1;
        if (v.sidx == STAMP_LAST) begin
          next_v.phase = PH_IDLE;
        end
      end
      default: next_v.phase = PH_IDLE;
    endcase
    if (v.phase != PH_IDLE && next_v.phase == PH_IDLE) begin
      next_v.line_cnt = v.line_cnt + 16'h1;
      next_v.line_b = ctrl.dual && !v.line_b;
    end
    if (!ctrl.stamp_en) begin
      next_v.line_cnt = 16'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      v <= VID_RST;
    end else begin
      v <= next_v;
    end
  end

  assign awready = b.awready;
  assign wready = b.wready;
  assign bvalid = b.bvalid;
  assign bresp = b.bresp;
  assign arready = b.arready;
  assign rvalid = b.rvalid;
  assign rdata = b.rdata;
  assign rresp = b.rresp;
  assign video = v.vid;

  a_ramp_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (v.phase == PH_IMAGE && $past(v.phase) == PH_IMAGE && ctrl.test == TEST_RAMP
     && ctrl.depth == DEPTH_8 && $stable(b.ctrl))
    |=> video.pixel == {4'h0, $past(video.pixel[7:0]) + 8'h01})
    else $error("ramp did not step by one");
  a_ramp_advance: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig && v.phase == PH_IDLE && area_len != 13'h0) |=> v.lbase == $past(v.ramp)
    && v.ramp == $past(v.ramp) + 8'h01)
    else $error("ramp start did not advance");
  a_black_line: assert property (@(posedge aclk) disable iff (!aresetn)
    (v.phase == PH_IMAGE && ctrl.test == TEST_BLACK) |=> video.pixel == 12'h000)
    else $error("black pixel not zero");
  a_gray_ten: assert property (@(posedge aclk) disable iff (!aresetn)
    (v.phase == PH_IMAGE && ctrl.test == TEST_GRAY && ctrl.depth == DEPTH_10)
    |=> video.pixel == 12'h1ff)
    else $error("gray pixel wrong at 10 bit");
  a_stamp_count: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(v.phase == PH_STAMP) |-> v.sidx == 4'h0 ##15 v.sidx == 4'hf ##1 v.phase == PH_IDLE)
    else $error("stamp not sixteen pixels");
  a_no_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    (v.phase == PH_IMAGE ##1 v.phase == PH_STAMP) |-> video.line_valid && video.data_valid
    ##1 (video.line_valid && video.data_valid)[*8])
    else $error("gap before or in stamp");
  a_sync_twelve: assert property (@(posedge aclk) disable iff (!aresetn)
    (v.phase == PH_STAMP && v.sidx == 4'h0 && ctrl.depth == DEPTH_12)
    |=> video.pixel == 12'haa0)
    else $error("stamp sync wrong");
  a_ten_lsbs: assert property (@(posedge aclk) disable iff (!aresetn)
    (v.phase == PH_STAMP && ctrl.depth == DEPTH_10) |=> video.pixel[1:0] == 2'b00
    && video.pixel[11:10] == 2'b00)
    else $error("10 bit stamp lsbs not zero");
  a_cnt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl.stamp_en |=> v.line_cnt == 16'h0)
    else $error("line counter not cleared");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (v.phase == PH_STAMP && (v.sidx == 4'h7 || v.sidx == 4'hf)) |=> video.pixel == 12'h000)
    else $error("reserved stamp pixel not zero");

endmodule

// ### tb/lts_grabber.sv
// frame grabber model: fires line triggers and collects the valid pixels
`timescale 1ns/1ns
module lts_grabber
  import lts_pkg::*;
(
  input wire logic aclk,
  input wire lts_video_t video,
  output logic external_line_trigger
);
  logic [11:0] cap [$];
  int dv_err = 0;
  initial external_line_trigger = 1'b0;
  // keeps every pixel seen with line valid; the two qualifiers must agree
  always @(posedge aclk) begin
    if (video.line_valid === 1'b1) cap.push_back(video.pixel);
    if (video.line_valid !== video.data_valid) dv_err++;
  end
  // pulse held two cycles so the synchroniser cannot miss it
  task automatic fire();
    cap.delete();
    @(posedge aclk);
    external_line_trigger <= 1'b1;
    repeat (2) @(posedge aclk);
    external_line_trigger <= 1'b0;
  endtask
endmodule

// ### tb/lts_top_test.sv
// self-checking bench for the line test pattern and stamp block
`timescale 1ns/1ns
module lts_top_test;
  import lts_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic external_line_trigger;
  logic [11:0] sensor_pixel, th, lim;
  lts_video_t video;
  logic [11:0] exp [$];
  int miscompares = 0;
  int check_count = 0;
  int base = 0;
  logic [15:0] lcount = 16'h0000;
  logic lineb = 1'b0;

  lts_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .external_line_trigger, .sensor_pixel, .video);
  lts_grabber grab (.aclk, .video, .external_line_trigger);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one triggered line; expectation built from the mode, area and running stats
  task automatic line(input lts_ctrl_t c, input int start, input int len);
    logic [11:0] v, pv;
    logic [23:0] sum, con;
    logic [15:0] hi, lo;
    logic [7:0] sb [16];
    int sh, n;
    sh = (c.depth == DEPTH_8) ? 0 : (c.depth == DEPTH_10) ? 2 : 4;
    exp.delete();
    sum = '0;
    con = '0;
    hi = '0;
    lo = '0;
    pv = '0;
    axi_write(ADDR_AREA, {3'h0, 13'(len), 3'h0, 13'(start)});
    axi_write(ADDR_CTRL, {25'h0, c});
    for (int i = 0; i < len; i++) begin
      case (c.test)
        TEST_RAMP: v = 12'((base + start + i) % 256) << sh;
        TEST_BLACK: v = 12'h000;
        TEST_GRAY: v = (sh == 0) ? 12'h07f : (sh == 2) ? 12'h1ff : 12'h7ff;
        default: v = sensor_pixel;
      endcase
      exp.push_back(v);
      sum += 24'(v);
      if (i > 0) con += 24'((v > pv) ? v - pv : pv - v);
      if (v > th) hi++;
      if (v < lim) lo++;
      pv = v;
    end
    if (!c.stamp_en) lcount = 16'h0000;
    sb = '{8'haa, (c.dual && lineb) ? 8'h57 : 8'h55, lcount[7:0], lcount[15:8], sum[7:0],
      sum[15:8], sum[23:16], 8'h00, hi[7:0], hi[15:8], lo[7:0], lo[15:8], con[7:0], con[15:8],
      con[23:16], 8'h00};
    if (c.stamp_en) foreach (sb[k]) exp.push_back(12'(sb[k]) << sh);
    grab.fire();
    n = 0;
    while (video.line_valid !== 1'b1 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    // a gap inside the line would end this wait early and shorten the capture
    while (video.line_valid === 1'b1 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    check(32'(grab.cap.size()), 32'(exp.size()));
    foreach (exp[k]) if (k < grab.cap.size()) check({20'h0, grab.cap[k]}, {20'h0, exp[k]});
    base++;
    if (c.stamp_en) lcount++;
    lineb = c.dual ? ~lineb : 1'b0;
  endtask

  task automatic test_bus();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(8'h20, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    axi_read(ADDR_LIMITS, d, r);
    check(d, 32'h0c80_0190);
    axi_write(ADDR_LIMITS, {4'h0, th, 4'h0, lim});
  endtask

  // first line starts the ramp at zero, later ones wrap and scale by depth
  task automatic test_ramp();
    line('{1'b0, 1'b0, 1'b0, DEPTH_8, TEST_RAMP}, 0, 4);
    line('{1'b0, 1'b0, 1'b0, DEPTH_10, TEST_RAMP}, 254, 4);
    line('{1'b0, 1'b0, 1'b0, DEPTH_12, TEST_RAMP}, 253, 4);
  endtask

  // a dual black line a before each stamped gray line makes every gray line b
  task automatic test_flat();
    for (int d = 0; d < 3; d++) begin
      line('{1'b1, 1'b0, 1'b0, lts_depth_t'(d), TEST_BLACK}, 5, 3);
      line('{1'b1, 1'b0, 1'b1, lts_depth_t'(d), TEST_GRAY}, 5, 3);
    end
  endtask

  // dual line a, then a plain line while line b is pending: both must show 0x55
  task automatic test_stamp();
    logic [31:0] d;
    logic [1:0] r;
    line('{1'b1, 1'b0, 1'b1, DEPTH_8, TEST_RAMP}, 250, 10);
    line('{1'b0, 1'b0, 1'b1, DEPTH_8, TEST_RAMP}, 250, 10);
    line('{1'b0, 1'b0, 1'b1, DEPTH_12, TEST_OFF}, 0, 5);
    axi_read(ADDR_STATUS, d, r);
    check(d, {14'h0, lineb, 1'b0, lcount});
  endtask

  // free-run ticks every period plus one cycles; the idle gap after a 5-pixel line shows it
  task automatic test_free_run();
    int t;
    t = 0;
    axi_write(ADDR_AREA, 32'h0005_0000);
    axi_write(ADDR_PERIOD, 32'h0000_0027);
    axi_write(ADDR_CTRL, 32'h0000_0022);
    while (video.line_valid !== 1'b1 && t < 200) begin
      @(posedge aclk);
      t++;
    end
    while (video.line_valid === 1'b1) @(posedge aclk);
    t = 0;
    while (video.line_valid !== 1'b1 && t < 200) begin
      @(posedge aclk);
      t++;
    end
    check(32'(t), 32'(40 - 5));
    axi_write(ADDR_CTRL, 32'h0);
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    sensor_pixel = 12'h9c3;
    th = 12'h100;
    lim = 12'h080;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    test_bus();
    test_ramp();
    test_flat();
    test_stamp();
    test_free_run();
    check(32'(grab.dv_err), 32'h0);
    complete_run();
  end

  // watchdog sized well above the several hundred cycles the scenarios need
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
endmodule
